//--- shared/rcf_pkg.sv
// package with the constants and carrier types of the reset-cause flag register block
package rcf_pkg;

  localparam int unsigned RCF_ADDR_W = 12;
  localparam int unsigned RCF_DATA_W = 32;
  localparam int unsigned RCF_STRB_W = 4;
  localparam int unsigned RCF_FLAGS_W = 8;
  localparam int unsigned RCF_SYNC_STAGES = 2;

  // byte address of the one register in this block
  localparam logic [RCF_ADDR_W-1:0] RCF_FLAGS_ADDR = 12'h000;

  // bit positions inside reset_cause_flags
  localparam int unsigned RCF_BIT_STACK_OVERFLOW = 7;
  localparam int unsigned RCF_BIT_STACK_UNDERFLOW = 6;
  localparam int unsigned RCF_BIT_UNUSED = 5;
  localparam int unsigned RCF_BIT_WATCHDOG_N = 4;
  localparam int unsigned RCF_BIT_PIN_N = 3;
  localparam int unsigned RCF_BIT_INSTR_N = 2;
  localparam int unsigned RCF_BIT_POWER_ON_N = 1;
  localparam int unsigned RCF_BIT_BROWN_OUT_N = 0;

  // value after power-on: stack flags 0, cause flags 1, power-on and brown-out 0
  localparam logic [RCF_FLAGS_W-1:0] RCF_POR_VALUE = 8'h1C;
  // bits that firmware can change; bit 5 is not implemented
  localparam logic [RCF_FLAGS_W-1:0] RCF_WRITE_MASK = 8'hDF;
  // brown-out forces these bits to one and these bits to zero, power-on flag is kept
  localparam logic [RCF_FLAGS_W-1:0] RCF_BOR_SET_MASK = 8'h1C;
  localparam logic [RCF_FLAGS_W-1:0] RCF_BOR_CLR_MASK = 8'hC1;

  localparam logic [RCF_DATA_W-1:0] RCF_READ_IDLE = 32'h0000_0000;

  // one-cycle cause events that arrive from logic on the core clock
  typedef struct packed {
    logic stack_overflow;
    logic stack_underflow;
    logic watchdog;
    logic instr;
  } rcf_event_type;

  // apb request as seen by the slave
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [RCF_ADDR_W-1:0] addr;
    logic [RCF_DATA_W-1:0] wdata;
    logic [RCF_STRB_W-1:0] strb;
  } rcf_apb_req_type;

endpackage

//--- design/rcf_sync.sv
// two-stage synchroniser for levels that arrive from outside the core clock
`timescale 1ns/1ns
`default_nettype none
module rcf_sync
  import rcf_pkg::*;
#(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // the first stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else if (ce_i) begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;

endmodule
`default_nettype wire

//--- design/rcf_top.sv
// reset-cause flag register with its apb slave
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - A stack overflow event sets bit 7, which stays set until firmware writes it to zero.
// - A stack underflow event sets bit 6, which stays set until firmware writes it to zero.
// - Bit 5 is not implemented, reads as zero and ignores writes.
// - A watchdog time-out reset clears bit 4, and firmware may write it back to one.
// - A reset through the external reset pin clears bit 3, and firmware may write it back to one.
// - A reset instruction clears bit 2, and firmware may write it back to one.
// - Power-on drives bit 1 to zero, and firmware must write it to one afterwards.
// - Brown-out drives bit 0 to zero, and firmware must write it to one after power-on or brown-out.
// - Power-on or brown-out loads zero into both stack flags and one into watchdog, pin and instruction flags.
// - The low-power supply monitor request is ORed with the brown-out request into one brown-out signal.
module rcf_top
  import rcf_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic SYS_RST_I,
  input wire logic CE_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [RCF_ADDR_W-1:0] PADDR_I,
  input wire logic [RCF_DATA_W-1:0] PWDATA_I,
  input wire logic [RCF_STRB_W-1:0] PSTRB_I,
  output logic [RCF_DATA_W-1:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic STACK_OVERFLOW_I,
  input wire logic STACK_UNDERFLOW_I,
  input wire logic WATCHDOG_RESET_I,
  input wire logic INSTR_RESET_I,
  input wire logic EXTERNAL_RESET_PIN_I,
  input wire logic BROWN_OUT_REQ_I,
  input wire logic LOW_POWER_SUPPLY_MONITOR_I,
  output logic BROWN_OUT_RESET_O,
  output logic [RCF_FLAGS_W-1:0] RESET_CAUSE_FLAGS_O
);

  rcf_apb_req_type apb_req;
  rcf_event_type cause_evt;
  logic [RCF_FLAGS_W-1:0] reset_cause_flags_reg;
  logic [RCF_FLAGS_W-1:0] reset_cause_flags_next;
  logic [RCF_FLAGS_W-1:0] after_write;
  logic [RCF_FLAGS_W-1:0] after_events;
  logic [RCF_DATA_W-1:0] prdata_reg;
  logic [RCF_DATA_W-1:0] prdata_next;
  logic [1:0] async_req;
  logic [1:0] sync_req;
  logic brown_out_raw;
  logic pin_reset_req;
  logic brown_out_req;
  logic addr_hit;
  logic access_phase;
  logic wr_en;
  logic rd_en;

  function automatic logic flags_addressed(input logic [RCF_ADDR_W-1:0] addr);
    flags_addressed = (addr == RCF_FLAGS_ADDR);
  endfunction

  assign apb_req = '{sel: PSEL_I, enable: PENABLE_I, write: PWRITE_I,
                     addr: PADDR_I, wdata: PWDATA_I, strb: PSTRB_I};
  assign cause_evt = '{stack_overflow: STACK_OVERFLOW_I, stack_underflow: STACK_UNDERFLOW_I,
                       watchdog: WATCHDOG_RESET_I, instr: INSTR_RESET_I};

  // both supply monitors merge before the synchroniser, so one path feeds flag and reset logic
  assign brown_out_raw = BROWN_OUT_REQ_I | LOW_POWER_SUPPLY_MONITOR_I;
  assign async_req = {EXTERNAL_RESET_PIN_I, brown_out_raw};

  rcf_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk_i(MCLK_I),
    .rst_i(SYS_RST_I),
    .ce_i(CE_I),
    .async_i(async_req),
    .sync_o(sync_req)
  );

  assign pin_reset_req = sync_req[1];
  assign brown_out_req = sync_req[0];
  assign BROWN_OUT_RESET_O = brown_out_req;

  // apb decode: zero wait states, unmapped addresses answer with an error
  assign access_phase = apb_req.sel & apb_req.enable;
  assign addr_hit = flags_addressed(apb_req.addr);
  assign wr_en = access_phase & apb_req.write & addr_hit & apb_req.strb[0] & CE_I;
  assign rd_en = apb_req.sel & ~apb_req.enable & ~apb_req.write & addr_hit;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = access_phase & ~addr_hit;

  // firmware write touches only implemented bits
  assign after_write = wr_en
    ? ((reset_cause_flags_reg & ~RCF_WRITE_MASK) | (apb_req.wdata[RCF_FLAGS_W-1:0] & RCF_WRITE_MASK))
    : reset_cause_flags_reg;

  // hardware events beat a same-cycle firmware write; other bits keep their value
  always_comb begin
    after_events = after_write;
    if (cause_evt.stack_overflow) begin
      after_events[RCF_BIT_STACK_OVERFLOW] = 1'b1;
    end
    if (cause_evt.stack_underflow) begin
      after_events[RCF_BIT_STACK_UNDERFLOW] = 1'b1;
    end
    if (cause_evt.watchdog) begin
      after_events[RCF_BIT_WATCHDOG_N] = 1'b0;
    end
    if (pin_reset_req) begin
      after_events[RCF_BIT_PIN_N] = 1'b0;
    end
    if (cause_evt.instr) begin
      after_events[RCF_BIT_INSTR_N] = 1'b0;
    end
  end

  // brown-out overrides the cause bits it loads, the power-on flag passes through
  assign reset_cause_flags_next = brown_out_req
    ? ((after_events | RCF_BOR_SET_MASK) & ~RCF_BOR_CLR_MASK)
    : after_events;

  // read data is captured in the setup cycle so that it stands through the access phase
  assign prdata_next = rd_en ? {{(RCF_DATA_W-RCF_FLAGS_W){1'b0}}, reset_cause_flags_reg} : RCF_READ_IDLE;

  // SYS_RST_I is the power-on reset of this register
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      reset_cause_flags_reg <= RCF_POR_VALUE;
    end else if (CE_I) begin
      reset_cause_flags_reg <= reset_cause_flags_next;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      prdata_reg <= RCF_READ_IDLE;
    end else if (CE_I) begin
      prdata_reg <= prdata_next;
    end
  end

  assign PRDATA_O = prdata_reg;
  assign RESET_CAUSE_FLAGS_O = reset_cause_flags_reg;

  // checks
  sequence s_overflow_event;
    CE_I && cause_evt.stack_overflow && !brown_out_req;
  endsequence

  sequence s_fw_clear_ovf;
    CE_I && wr_en && !apb_req.wdata[RCF_BIT_STACK_OVERFLOW] && !cause_evt.stack_overflow && !brown_out_req;
  endsequence

  a_ovf_flag_set: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    s_overflow_event |=> reset_cause_flags_reg[RCF_BIT_STACK_OVERFLOW])
    else $error("stack overflow did not set its flag");

  a_ovf_flag_hold: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    reset_cause_flags_reg[RCF_BIT_STACK_OVERFLOW] && !brown_out_req
      && !(wr_en && !apb_req.wdata[RCF_BIT_STACK_OVERFLOW])
      |=> reset_cause_flags_reg[RCF_BIT_STACK_OVERFLOW])
    else $error("stack overflow flag dropped without a firmware clear");

  a_ovf_fw_clear: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    s_fw_clear_ovf |=> !reset_cause_flags_reg[RCF_BIT_STACK_OVERFLOW])
    else $error("firmware write of zero did not clear the stack overflow flag");

  a_unf_flag_set: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    CE_I && cause_evt.stack_underflow && !brown_out_req |=> reset_cause_flags_reg[RCF_BIT_STACK_UNDERFLOW])
    else $error("stack underflow did not set its flag");

  a_unused_bit_zero: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    wr_en |=> !reset_cause_flags_reg[RCF_BIT_UNUSED] && !prdata_reg[RCF_BIT_UNUSED])
    else $error("unimplemented bit reads as one");

  a_wdt_flag_clear: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    CE_I && cause_evt.watchdog && !brown_out_req |=> !reset_cause_flags_reg[RCF_BIT_WATCHDOG_N])
    else $error("watchdog reset did not clear its flag");

  a_pin_flag_clear: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    CE_I && EXTERNAL_RESET_PIN_I && !brown_out_req ##1 CE_I ##1 CE_I && !brown_out_req
      |=> !reset_cause_flags_reg[RCF_BIT_PIN_N])
    else $error("pin reset did not clear its flag within three cycles");

  a_instr_flag_clear: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    CE_I && cause_evt.instr && !brown_out_req |=> !reset_cause_flags_reg[RCF_BIT_INSTR_N])
    else $error("reset instruction did not clear its flag");

  a_instr_flag_rearm: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    wr_en && apb_req.wdata[RCF_BIT_INSTR_N] && !cause_evt.instr && !brown_out_req
      |=> reset_cause_flags_reg[RCF_BIT_INSTR_N])
    else $error("instruction flag not re-armed by firmware");

  a_por_flag_kept: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    CE_I && !wr_en |=> $stable(reset_cause_flags_reg[RCF_BIT_POWER_ON_N]))
    else $error("power-on flag changed without a firmware write");

  a_bor_load_value: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    CE_I && brown_out_req |=> (reset_cause_flags_reg & (RCF_BOR_SET_MASK | RCF_BOR_CLR_MASK)) == RCF_BOR_SET_MASK)
    else $error("brown-out did not load the documented flag values");

  a_lp_monitor_merge: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    CE_I && LOW_POWER_SUPPLY_MONITOR_I ##1 CE_I && LOW_POWER_SUPPLY_MONITOR_I |=> BROWN_OUT_RESET_O)
    else $error("low-power monitor request not seen as brown-out");

  a_idle_flags_kept: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    !wr_en && !brown_out_req && !pin_reset_req && !(|cause_evt) |=> $stable(reset_cause_flags_reg))
    else $error("flags changed with no cause and no write");

  a_freeze_on_ce: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    !CE_I |=> $stable(reset_cause_flags_reg) && $stable(prdata_reg))
    else $error("state moved while clock enable was low");

endmodule
`default_nettype wire

//--- tb/rcf_top_test.sv
// self-checking testbench for the reset-cause flag register
`timescale 1ns/1ns
`default_nettype none
module rcf_top_test
  import rcf_pkg::*;
;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [RCF_ADDR_W-1:0] paddr = '0;
  logic [RCF_DATA_W-1:0] pwdata = '0;
  logic [RCF_STRB_W-1:0] pstrb = '0;
  rcf_event_type ev = '0;
  logic pin = 1'b0;
  logic bo_req = 1'b0;
  logic lpm = 1'b0;
  logic ce = 1'b1;
  logic [RCF_DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic bo_rst;
  logic [RCF_FLAGS_W-1:0] flags;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [7:0] pre_tab [7] = '{8'h1F, 8'h1F, 8'h1F, 8'h1F, 8'h1F, 8'hDF, 8'hC3};
  logic [7:0] exp_tab [7] = '{8'h9F, 8'h5F, 8'h0F, 8'h1B, 8'h17, 8'h1E, 8'h1E};

  rcf_top uut (
    .MCLK_I(mclk), .SYS_RST_I(sys_rst), .CE_I(ce),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .STACK_OVERFLOW_I(ev.stack_overflow), .STACK_UNDERFLOW_I(ev.stack_underflow),
    .WATCHDOG_RESET_I(ev.watchdog), .INSTR_RESET_I(ev.instr), .EXTERNAL_RESET_PIN_I(pin),
    .BROWN_OUT_REQ_I(bo_req), .LOW_POWER_SUPPLY_MONITOR_I(lpm),
    .BROWN_OUT_RESET_O(bo_rst), .RESET_CAUSE_FLAGS_O(flags)
  );

  initial begin
    forever #10 mclk = ~mclk;
  end

  task automatic give_verdict;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // a hung handshake must still end in the closing report
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      $display("BAD timeout expected end seen hang");
      failures++;
      give_verdict();
    end
  end

  task automatic check(input string what, input logic [31:0] expv, input logic [31:0] seen);
    n_compared++;
    if (seen !== expv) begin
      $display("BAD %s expected %h seen %h", what, expv, seen);
      failures++;
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    // the slave answers with no wait state, so the first access edge completes
    check("wait_cycles", 32'h1, n);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic e);
    logic [31:0] r;
    logic x;
    apb(1'b1, a, d, s, r, x);
    check("write_err", {31'h0, e}, {31'h0, x});
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] expv, input logic e);
    logic [31:0] r;
    logic x;
    apb(1'b0, a, 32'h0, 4'h0, r, x);
    check("read_data", expv, r);
    check("read_err", {31'h0, e}, {31'h0, x});
  endtask

  // flags are looked at mid-cycle, after the edge's updates have landed
  task automatic chk_flags(input logic [7:0] expv);
    @(negedge mclk);
    check("flags", {24'h0, expv}, {24'h0, flags});
  endtask

  // same-clock causes pulse once; async requests are held past the synchroniser
  task automatic fire(input int k);
    @(posedge mclk);
    case (k)
      0: ev.stack_overflow <= 1'b1;
      1: ev.stack_underflow <= 1'b1;
      2: ev.watchdog <= 1'b1;
      3: ev.instr <= 1'b1;
      4: pin <= 1'b1;
      5: bo_req <= 1'b1;
      default: lpm <= 1'b1;
    endcase
    repeat ((k > 3) ? 4 : 1) @(posedge mclk);
    if (k > 4) check("bo_reset_on", 32'h1, {31'h0, bo_rst});
    ev <= '0;
    pin <= 1'b0;
    bo_req <= 1'b0;
    lpm <= 1'b0;
    repeat (4) @(posedge mclk);
    check("bo_reset_off", 32'h0, {31'h0, bo_rst});
  endtask

  initial begin
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    chk_flags(RCF_POR_VALUE);
    rd(RCF_FLAGS_ADDR, 32'h0000_001C, 1'b0);
    wr(RCF_FLAGS_ADDR, 32'hFFFF_FFFF, 4'hF, 1'b0);
    chk_flags(8'hDF);
    rd(RCF_FLAGS_ADDR, 32'h0000_00DF, 1'b0);
    wr(RCF_FLAGS_ADDR, 32'h0000_0000, 4'hF, 1'b0);
    chk_flags(8'h00);
    wr(RCF_FLAGS_ADDR, 32'h0000_00FF, 4'h0, 1'b0);
    chk_flags(8'h00);
    wr(12'h004, 32'h0000_00FF, 4'hF, 1'b1);
    chk_flags(8'h00);
    rd(12'h004, 32'h0, 1'b1);
    for (int k = 0; k < 7; k++) begin
      wr(RCF_FLAGS_ADDR, {24'h0, pre_tab[k]}, 4'h1, 1'b0);
      fire(k);
      chk_flags(exp_tab[k]);
      rd(RCF_FLAGS_ADDR, {24'h0, exp_tab[k]}, 1'b0);
    end
    // an overflow pulse while the clock enable is low must be lost
    @(posedge mclk);
    ce <= 1'b0;
    ev.stack_overflow <= 1'b1;
    @(posedge mclk);
    ev <= '0;
    @(posedge mclk);
    ce <= 1'b1;
    chk_flags(8'h1E);
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    chk_flags(RCF_POR_VALUE);
    rd(RCF_FLAGS_ADDR, 32'h0000_001C, 1'b0);
    give_verdict();
  end
endmodule
`default_nettype wire
